/* File: hw/probe_capture_homing_params.v */
`timescale 1ns/1ps
module probe_capture_homing_params #(
	parameter POS_W = 32
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             sys_rst,
	// Probe pins, asynchronous
	input  wire             probe1_pin,
	input  wire             probe2_pin,
	// Measuring cycle and position feedback, same clock
	input  wire             measure_active,
	input  wire [POS_W-1:0] motor_position,
	input  wire [POS_W-1:0] external_position,
	// Cyclic words, same clock
	input  wire [15:0]      host_command_word,
	input  wire [15:0]      drive_state_word,
	// Acceleration path
	input  wire [31:0]      accel_command,
	output reg  [31:0]      accel_limited_q,
	// Homing setup decoded
	output reg              homing_decreasing_q,
	output reg              homing_marker_after_fall_q,
	output reg              homing_switch_at_drive_q,
	output reg              homing_external_feedback_q,
	output reg              homing_skip_switch_q,
	output reg              homing_skip_marker_q,
	// Service channel
	input  wire             svc_req,
	input  wire             svc_wr,
	input  wire [15:0]      svc_idn,
	input  wire [7:0]       svc_idx,
	input  wire [31:0]      svc_wdata,
	output reg              svc_ack_q,
	output reg              svc_err_q,
	output reg  [31:0]      svc_rdata_q
);

`include "probe_capture_homing_params_regs.vh"

	// Arbitrary identification texts, not tied to any real product
	function [7:0] ctrl_type_char;
		input [7:0] idx;
		begin
			case (idx)
				8'h00:   ctrl_type_char = 8'h44;
				8'h01:   ctrl_type_char = 8'h52;
				8'h02:   ctrl_type_char = 8'h56;
				8'h03:   ctrl_type_char = 8'h2D;
				8'h04:   ctrl_type_char = 8'h43;
				8'h05:   ctrl_type_char = 8'h54;
				8'h06:   ctrl_type_char = 8'h52;
				8'h07:   ctrl_type_char = 8'h4C;
				default: ctrl_type_char = 8'h00;
			endcase
		end
	endfunction

	// Arbitrary version string V00.00
	function [7:0] if_version_char;
		input [7:0] idx;
		begin
			case (idx)
				8'h00:   if_version_char = 8'h56;
				8'h01:   if_version_char = 8'h30;
				8'h02:   if_version_char = 8'h30;
				8'h03:   if_version_char = 8'h2E;
				8'h04:   if_version_char = 8'h30;
				8'h05:   if_version_char = 8'h30;
				default: if_version_char = 8'h00;
			endcase
		end
	endfunction

	// Packs one text element: length above, character below
	function [31:0] text_word;
		input [7:0] len;
		input [7:0] ch;
		begin
			text_word = {16'h0000, len, ch};
		end
	endfunction

	reg  [POS_W-1:0] probe_source_pos;
	wire [POS_W-1:0] probe1_rise;
	wire [POS_W-1:0] probe1_fall;
	wire [POS_W-1:0] probe2_rise;
	wire [POS_W-1:0] probe2_fall;

	reg              probe_source_q;
	reg  [15:0]      host_cmd_copy_q;
	reg  [15:0]      drive_state_copy_q;
	reg  [31:0]      accel_limit_q;
	reg  [15:0]      homing_setup_q;
	reg  [7:0]       app_text_q [0:`APP_TEXT_DEPTH-1];
	reg  [7:0]       app_len_q;
	reg  [POS_W-1:0] pos_sample_q;

	reg  [31:0]      rd_d;
	reg              err_d;
	reg  [7:0]       app_char;
	wire [31:0]      neg_limit;
	wire             wr_go;
	integer          i;

	// Position sampled one cycle late so it lines up with the synchronised edge
	always @* begin
		if (probe_source_q) begin
			probe_source_pos = external_position;
		end else begin
			probe_source_pos = motor_position;
		end
	end

	always @(posedge mclk) begin
		if (sys_rst) begin
			pos_sample_q <= `RST_POSITION;
		end else begin
			pos_sample_q <= probe_source_pos;
		end
	end

	probe_edge_latch #(
		.POS_W(POS_W)
	) u_probe1 (
		.mclk           (mclk),
		.sys_rst        (sys_rst),
		.probe_pin      (probe1_pin),
		.measure_active (measure_active),
		.position       (pos_sample_q),
		.rise_pos_q     (probe1_rise),
		.fall_pos_q     (probe1_fall)
	);

	// Second probe uses the same latch
	probe_edge_latch #(
		.POS_W(POS_W)
	) u_probe2 (
		.mclk           (mclk),
		.sys_rst        (sys_rst),
		.probe_pin      (probe2_pin),
		.measure_active (measure_active),
		.position       (pos_sample_q),
		.rise_pos_q     (probe2_rise),
		.fall_pos_q     (probe2_fall)
	);

	// Cyclic word copies
	always @(posedge mclk) begin
		if (sys_rst) begin
			host_cmd_copy_q    <= `RST_WORD16;
			drive_state_copy_q <= `RST_WORD16;
		end else begin
			host_cmd_copy_q    <= host_command_word;
			drive_state_copy_q <= drive_state_word;
		end
	end

	// Symmetric acceleration clamp
	assign neg_limit = 32'h00000000 - accel_limit_q;

	always @(posedge mclk) begin
		if (sys_rst) begin
			accel_limited_q <= 32'h00000000;
		end else if ($signed(accel_command) > $signed(accel_limit_q)) begin
			accel_limited_q <= accel_limit_q;
		end else if ($signed(accel_command) < $signed(neg_limit)) begin
			accel_limited_q <= neg_limit;
		end else begin
			accel_limited_q <= accel_command;
		end
	end

	// Homing setup fanned out as flops
	always @(posedge mclk) begin
		if (sys_rst) begin
			homing_decreasing_q        <= 1'b0;
			homing_marker_after_fall_q <= 1'b0;
			homing_switch_at_drive_q   <= 1'b0;
			homing_external_feedback_q <= 1'b0;
			homing_skip_switch_q       <= 1'b0;
			homing_skip_marker_q       <= 1'b0;
		end else begin
			homing_decreasing_q        <= homing_setup_q[`HOME_DIR_BIT];
			homing_marker_after_fall_q <= homing_setup_q[`HOME_MARKER_BIT];
			homing_switch_at_drive_q   <= homing_setup_q[`HOME_SWITCH_LOC_BIT];
			homing_external_feedback_q <= homing_setup_q[`HOME_FEEDBACK_BIT];
			homing_skip_switch_q       <= homing_setup_q[`HOME_SWITCH_EVAL_BIT];
			homing_skip_marker_q       <= homing_setup_q[`HOME_MARKER_EVAL_BIT];
		end
	end

	// Application text element read
	always @* begin
		if (svc_idx < app_len_q && svc_idx < `APP_TEXT_DEPTH) begin
			app_char = app_text_q[svc_idx[3:0]];
		end else begin
			app_char = 8'h00;
		end
	end

	// Service channel decode
	always @* begin
		rd_d  = 32'h00000000;
		err_d = 1'b0;
		case (svc_idn)
			`IDN_PROBE1_RISE: begin
				rd_d  = probe1_rise;
				err_d = svc_wr;
			end
			`IDN_PROBE1_FALL: begin
				rd_d  = probe1_fall;
				err_d = svc_wr;
			end
			`IDN_PROBE2_RISE: begin
				rd_d  = probe2_rise;
				err_d = svc_wr;
			end
			`IDN_PROBE2_FALL: begin
				rd_d  = probe2_fall;
				err_d = svc_wr;
			end
			`IDN_HOST_CMD_COPY: begin
				rd_d  = {16'h0000, host_cmd_copy_q};
				err_d = svc_wr;
			end
			`IDN_DRIVE_STATE_COPY: begin
				rd_d  = {16'h0000, drive_state_copy_q};
				err_d = svc_wr;
			end
			`IDN_ACCEL_LIMIT: begin
				rd_d  = accel_limit_q;
				err_d = svc_wr && (svc_wdata > `ACCEL_LIMIT_MAX);
			end
			`IDN_CTRL_TYPE_TEXT: begin
				rd_d  = text_word(`CTRL_TYPE_LEN, ctrl_type_char(svc_idx));
				err_d = svc_wr;
			end
			`IDN_APP_TYPE_TEXT: begin
				rd_d  = text_word(app_len_q, app_char);
				err_d = svc_wr && (svc_idx >= `APP_TEXT_DEPTH);
			end
			`IDN_IF_VERSION_TEXT: begin
				rd_d  = text_word(`IF_VERSION_LEN, if_version_char(svc_idx));
				err_d = svc_wr;
			end
			`IDN_HOMING_SETUP: begin
				rd_d  = {16'h0000, homing_setup_q};
			end
			`IDN_PROBE_SOURCE: begin
				rd_d  = {31'h00000000, probe_source_q};
			end
			default: begin
				err_d = 1'b1;
			end
		endcase
	end

	assign wr_go = svc_req && svc_wr && !err_d;

	// Writable parameters; refused writes leave contents untouched
	always @(posedge mclk) begin
		if (sys_rst) begin
			accel_limit_q  <= `RST_ACCEL_LIMIT;
			homing_setup_q <= `RST_HOMING_SETUP;
			probe_source_q <= `RST_PROBE_SOURCE;
			app_len_q      <= `RST_APP_TEXT_LEN;
		end else if (wr_go) begin
			case (svc_idn)
				`IDN_ACCEL_LIMIT: begin
					accel_limit_q <= svc_wdata;
				end
				`IDN_HOMING_SETUP: begin
					homing_setup_q <= svc_wdata[15:0];
				end
				`IDN_PROBE_SOURCE: begin
					probe_source_q <= svc_wdata[0];
				end
				`IDN_APP_TYPE_TEXT: begin
					app_len_q <= svc_wdata[15:8];
				end
				default: begin
					app_len_q <= app_len_q;
				end
			endcase
		end
	end

	// Text storage has no reset; its content is undefined until written
	always @(posedge mclk) begin
		for (i = 0; i < `APP_TEXT_DEPTH; i = i + 1) begin
			if (wr_go && svc_idn == `IDN_APP_TYPE_TEXT && svc_idx[3:0] == i[3:0]) begin
				app_text_q[i] <= svc_wdata[7:0];
			end
		end
	end

	// Answer one cycle after each request
	always @(posedge mclk) begin
		if (sys_rst) begin
			svc_ack_q   <= 1'b0;
			svc_err_q   <= 1'b0;
			svc_rdata_q <= 32'h00000000;
		end else begin
			svc_ack_q <= svc_req;
			svc_err_q <= svc_req && err_d;
			if (svc_req && !svc_wr) begin
				svc_rdata_q <= rd_d;
			end
		end
	end

endmodule

/* File: hw/probe_edge_latch.v */
`timescale 1ns/1ps
module probe_edge_latch #(
	parameter POS_W = 32
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             sys_rst,
	// Probe pin and qualification
	input  wire             probe_pin,
	input  wire             measure_active,
	input  wire [POS_W-1:0] position,
	// Captured values
	output reg  [POS_W-1:0] rise_pos_q,
	output reg  [POS_W-1:0] fall_pos_q
);

`include "probe_capture_homing_params_regs.vh"

	reg meta_q;
	reg sync_q;
	reg last_q;
	reg seen_q;

	// Edge history resets low, so a pin held high through reset is captured as a rising edge
	always @(posedge mclk) begin
		if (sys_rst) begin
			meta_q     <= 1'b0;
			sync_q     <= 1'b0;
			last_q     <= 1'b0;
			seen_q     <= 1'b0;
			rise_pos_q <= `RST_POSITION;
			fall_pos_q <= `RST_POSITION;
		end else begin
			meta_q <= probe_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
			seen_q <= 1'b1;
			if (seen_q && measure_active && sync_q && !last_q) begin
				rise_pos_q <= position;
			end
			if (seen_q && measure_active && !sync_q && last_q) begin
				fall_pos_q <= position;
			end
			// Otherwise both hold their last capture
		end
	end

endmodule

/* File: inc/probe_capture_homing_params_regs.vh */
`ifndef PROBE_CAPTURE_HOMING_PARAMS_REGS_VH
`define PROBE_CAPTURE_HOMING_PARAMS_REGS_VH

// Parameter numbers on the service channel
`define IDN_PROBE1_RISE      16'h0082
`define IDN_PROBE1_FALL      16'h0083
`define IDN_PROBE2_RISE      16'h0084
`define IDN_PROBE2_FALL      16'h0085
`define IDN_HOST_CMD_COPY    16'h0086
`define IDN_DRIVE_STATE_COPY 16'h0087
`define IDN_ACCEL_LIMIT      16'h008A
`define IDN_CTRL_TYPE_TEXT   16'h008C
`define IDN_APP_TYPE_TEXT    16'h008E
`define IDN_IF_VERSION_TEXT  16'h008F
`define IDN_HOMING_SETUP     16'h0093
`define IDN_PROBE_SOURCE     16'h81B0

// Reset values
`define RST_POSITION         32'h00000000
`define RST_WORD16           16'h0000
`define RST_HOMING_SETUP     16'h0000
`define RST_PROBE_SOURCE     1'b0
// 25000.000 rad/s^2 in 0.001 steps
`define ACCEL_LIMIT_MAX      32'h017D7840
`define RST_ACCEL_LIMIT      32'h017D7840

// Homing setup field positions
`define HOME_DIR_BIT         0
`define HOME_MARKER_BIT      1
`define HOME_SWITCH_LOC_BIT  2
`define HOME_FEEDBACK_BIT    3
`define HOME_SWITCH_EVAL_BIT 5
`define HOME_MARKER_EVAL_BIT 6

// Text layout
`define TEXT_CHAR_LSB        0
`define TEXT_LEN_LSB         8
`define CTRL_TYPE_LEN        8'h08
`define IF_VERSION_LEN       8'h06
`define APP_TEXT_DEPTH       16
`define RST_APP_TEXT_LEN     8'h00

`endif

/* File: test/motion_ctrl_model.sv */
`timescale 1ns/1ps
module motion_ctrl_model (
	// Clock
	input  wire        mclk,
	// Bench requests
	input  wire        go,
	input  wire        wr,
	input  wire [15:0] idn,
	input  wire [7:0]  idx,
	input  wire [31:0] wdata,
	// Service channel
	output reg         svc_req = 1'b0,
	output reg         svc_wr = 1'b0,
	output reg  [15:0] svc_idn = 16'h0000,
	output reg  [7:0]  svc_idx = 8'h00,
	output reg  [31:0] svc_wdata = 32'h00000000
);
	// Probe edge enables are not set on this channel; both edges are captured on each probe
	always @(posedge mclk) begin
		svc_req <= go;
		if (go) begin
			svc_wr <= wr;
			svc_idn <= idn;
			svc_idx <= idx;
			// Homing writes always mark the switch at the drive and motor feedback
			if (idn == 16'h0093) begin
				svc_wdata <= (wdata | 32'h00000004) & 32'hFFFFFFF7;
			end else begin
				svc_wdata <= wdata;
			end
		end else begin
			// Idle lines keep moving so stale values never pass for a request
			svc_wr <= ~svc_wr;
			svc_idn <= ~svc_idn;
			svc_idx <= ~svc_idx;
			svc_wdata <= ~svc_wdata;
		end
	end
endmodule

/* File: test/probe_capture_homing_params_properties.sv */
`timescale 1ns/1ps
`include "probe_capture_homing_params_regs.vh"
module probe_capture_homing_params_checker (
	// Clock and reset
	input wire        mclk,
	input wire        sys_rst,
	// Observed ports
	input wire [31:0] accel_command,
	input wire [31:0] accel_limited_q,
	input wire        homing_decreasing_q,
	input wire        homing_marker_after_fall_q,
	input wire [15:0] drive_state_word,
	input wire        svc_req,
	input wire        svc_wr,
	input wire [15:0] svc_idn,
	input wire [31:0] svc_wdata,
	input wire        svc_ack_q,
	input wire        svc_err_q,
	input wire [31:0] svc_rdata_q
);
	reg  [31:0] lim_q;
	reg  [1:0]  quiet_q;
	wire        lim_wr = svc_req && svc_wr && svc_idn == `IDN_ACCEL_LIMIT;
	function [31:0] clamp(input [31:0] c, input [31:0] l);
		if ($signed(c) > $signed(l)) clamp = l;
		else if ($signed(c) < -$signed(l)) clamp = -l;
		else clamp = c;
	endfunction
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Clamp is only judged once a limit write has surely taken effect
	always @(posedge mclk) begin
		if (sys_rst) begin
			lim_q <= `RST_ACCEL_LIMIT;
			quiet_q <= 2'h0;
		end else if (lim_wr) begin
			if (svc_wdata <= `ACCEL_LIMIT_MAX) lim_q <= svc_wdata;
			quiet_q <= 2'h0;
		end else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
	end
	sequence home_wr;
		svc_req && svc_wr && svc_idn == `IDN_HOMING_SETUP;
	endsequence
	ack_follows_a: assert property (svc_req |=> svc_ack_q)
		else $error("no answer one cycle after request");
	ack_cause_a: assert property (svc_ack_q |-> $past(svc_req))
		else $error("answer without request");
	ro_refuse_a: assert property (svc_req && svc_wr && svc_idn == `IDN_HOST_CMD_COPY
		|=> svc_ack_q && svc_err_q) else $error("command copy write accepted");
	status_copy_a: assert property (svc_req && !svc_wr && svc_idn == `IDN_DRIVE_STATE_COPY
		&& $stable(drive_state_word) && !$past(sys_rst)
		|=> svc_rdata_q[15:0] == $past(drive_state_word)) else $error("status copy wrong");
	limit_refuse_a: assert property (lim_wr && svc_wdata > `ACCEL_LIMIT_MAX |=> svc_err_q)
		else $error("oversized limit accepted");
	clamp_sym_a: assert property (quiet_q == 2'h3 |->
		accel_limited_q == clamp($past(accel_command), lim_q)) else $error("clamp wrong");
	type_len_a: assert property (svc_req && !svc_wr && svc_idn == `IDN_CTRL_TYPE_TEXT
		|=> svc_rdata_q[15:8] == `CTRL_TYPE_LEN && !svc_err_q) else $error("type text");
	ver_len_a: assert property (svc_req && !svc_wr && svc_idn == `IDN_IF_VERSION_TEXT
		|=> svc_rdata_q[15:8] == `IF_VERSION_LEN && !svc_err_q) else $error("version");
	home_dir_a: assert property (home_wr |-> ##2
		homing_decreasing_q == $past(svc_wdata[0], 2)) else $error("direction bit");
	home_marker_a: assert property (home_wr |-> ##2
		homing_marker_after_fall_q == $past(svc_wdata[1], 2)) else $error("marker bit");
endmodule
bind probe_capture_homing_params probe_capture_homing_params_checker i_checker (
	.mclk, .sys_rst, .accel_command, .accel_limited_q, .homing_decreasing_q,
	.homing_marker_after_fall_q, .drive_state_word, .svc_req, .svc_wr, .svc_idn,
	.svc_wdata, .svc_ack_q, .svc_err_q, .svc_rdata_q
);

/* File: test/tb_probe_capture_homing_params.sv */
`timescale 1ns/1ps
`include "probe_capture_homing_params_regs.vh"
module tb_probe_capture_homing_params;
	localparam [32:0] OK  = 33'h000000000;
	localparam [32:0] ERR = 33'h100000000;
	reg         mclk = 1'b0;
	reg         sys_rst = 1'b1;
	reg         probe1_pin = 1'b0;
	reg         probe2_pin = 1'b0;
	reg         measure_active = 1'b1;
	reg  [31:0] motor_position = 32'h00000000;
	reg  [31:0] external_position = 32'h00000000;
	reg  [15:0] host_command_word = 16'hA5C3;
	reg  [15:0] drive_state_word = 16'h3C5A;
	reg  [31:0] accel_command = 32'h00000000;
	reg         go = 1'b0;
	reg         wr = 1'b0;
	reg  [15:0] idn = 16'h0000;
	reg  [7:0]  idx = 8'h00;
	reg  [31:0] wdata = 32'h00000000;
	wire        svc_req, svc_wr, svc_ack_q, svc_err_q;
	wire [15:0] svc_idn;
	wire [7:0]  svc_idx;
	wire [31:0] svc_wdata, svc_rdata_q, accel_limited_q;
	wire        homing_decreasing_q, homing_marker_after_fall_q;
	wire        homing_switch_at_drive_q, homing_external_feedback_q;
	wire        homing_skip_switch_q, homing_skip_marker_q;
	integer     mismatches = 0;
	integer     num_checks = 0;
	always #25 mclk = ~mclk;
	probe_capture_homing_params i_probe_capture_homing_params (
		.mclk, .sys_rst, .probe1_pin, .probe2_pin, .measure_active, .motor_position,
		.external_position, .host_command_word, .drive_state_word, .accel_command,
		.accel_limited_q, .homing_decreasing_q, .homing_marker_after_fall_q,
		.homing_switch_at_drive_q, .homing_external_feedback_q,
		.homing_skip_switch_q, .homing_skip_marker_q, .svc_req, .svc_wr,
		.svc_idn, .svc_idx, .svc_wdata, .svc_ack_q, .svc_err_q, .svc_rdata_q
	);
	motion_ctrl_model i_motion_ctrl_model (
		.mclk, .go, .wr, .idn, .idx, .wdata, .svc_req, .svc_wr, .svc_idn, .svc_idx,
		.svc_wdata
	);
	task test_done;
		begin
			$display("checks %0d mismatches %0d", num_checks, mismatches);
			if (mismatches == 0 && num_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [32:0] got, input [32:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Masked read data: unused upper bits of short words are not judged
	task acc(input w, input [15:0] n, input [7:0] x, input [31:0] d, input [31:0] m,
		input [32:0] e);
		integer k;
		begin
			go <= 1'b1;
			wr <= w;
			idn <= n;
			idx <= x;
			wdata <= d;
			@(posedge mclk);
			go <= 1'b0;
			for (k = 0; k < 8 && svc_ack_q !== 1'b1; k = k + 1)
				@(posedge mclk);
			chk({svc_err_q, svc_rdata_q & m}, e);
		end
	endtask
	task acl(input [31:0] c, input [31:0] e);
		begin
			accel_command <= c;
			repeat (2) @(posedge mclk);
			chk({1'b0, accel_limited_q}, {1'b0, e});
		end
	endtask
	// Pulses last six cycles, well past the two-stage synchroniser
	task pin(input integer p, input v);
		begin
			if (p == 1) probe1_pin <= v;
			else probe2_pin <= v;
			repeat (6) @(posedge mclk);
		end
	endtask
	task home(input [31:0] d, input [32:0] e);
		begin
			acc(1, `IDN_HOMING_SETUP, 8'h00, d, 32'h00000000, OK);
			repeat (2) @(posedge mclk);
			chk({27'h0, homing_skip_marker_q, homing_skip_switch_q, homing_external_feedback_q,
				homing_switch_at_drive_q, homing_decreasing_q, homing_marker_after_fall_q}, e);
		end
	endtask
	initial begin
		repeat (3000) @(posedge mclk);
		mismatches = mismatches + 1;
		test_done;
	end
	initial begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		acc(0, `IDN_ACCEL_LIMIT, 8'h00, 0, 32'hFFFFFFFF, {1'b0, `RST_ACCEL_LIMIT});
		acc(0, `IDN_HOMING_SETUP, 8'h00, 0, 32'h0000FFFF, OK);
		acc(0, `IDN_HOST_CMD_COPY, 8'h00, 0, 32'h0000FFFF, 33'h00000A5C3);
		acc(1, `IDN_HOST_CMD_COPY, 8'h00, 0, 32'h00000000, ERR);
		acc(0, `IDN_DRIVE_STATE_COPY, 8'h00, 0, 32'h0000FFFF, 33'h000003C5A);
		acc(1, `IDN_DRIVE_STATE_COPY, 8'h00, 0, 32'h00000000, ERR);
		acc(0, 16'h0000, 8'h00, 0, 32'h00000000, ERR);
		$display("word copies done");
		acl(32'h00002710, 32'h00002710);
		acc(1, `IDN_ACCEL_LIMIT, 8'h00, 32'h000003E8, 32'h00000000, OK);
		acl(32'h00001388, 32'h000003E8);
		acl(32'hFFFFEC78, 32'hFFFFFC18);
		acl(32'hFFFFFE0C, 32'hFFFFFE0C);
		acc(1, `IDN_ACCEL_LIMIT, 8'h00, 32'h017D7841, 32'h00000000, ERR);
		acc(0, `IDN_ACCEL_LIMIT, 8'h00, 0, 32'hFFFFFFFF, 33'h0000003E8);
		$display("limit done");
		acc(0, `IDN_CTRL_TYPE_TEXT, 8'h00, 0, 32'h0000FF00, {17'h0, `CTRL_TYPE_LEN, 8'h00});
		acc(1, `IDN_CTRL_TYPE_TEXT, 8'h00, 0, 32'h00000000, ERR);
		acc(0, `IDN_IF_VERSION_TEXT, 8'h00, 0, 32'h0000FF00, {17'h0, `IF_VERSION_LEN, 8'h00});
		acc(1, `IDN_IF_VERSION_TEXT, 8'h00, 0, 32'h00000000, ERR);
		acc(1, `IDN_APP_TYPE_TEXT, 8'h0F, 32'h00001051, 32'h00000000, OK);
		acc(0, `IDN_APP_TYPE_TEXT, 8'h0F, 0, 32'h0000FFFF, 33'h000001051);
		acc(1, `IDN_APP_TYPE_TEXT, 8'h10, 32'h00001052, 32'h00000000, ERR);
		$display("texts done");
		home(32'h00000063, 33'h000000037);
		acc(0, `IDN_HOMING_SETUP, 8'h00, 0, 32'h0000FFFF, 33'h000000067);
		home(32'h00000000, 33'h000000004);
		$display("homing done");
		motor_position <= 32'h00000011;
		pin(1, 1'b1);
		motor_position <= 32'h00000022;
		pin(1, 1'b0);
		acc(1, `IDN_PROBE_SOURCE, 8'h00, 32'h00000001, 32'h00000000, OK);
		external_position <= 32'hFFFFFF85;
		pin(2, 1'b1);
		external_position <= 32'h00000044;
		pin(2, 1'b0);
		measure_active <= 1'b0;
		external_position <= 32'h00000099;
		pin(2, 1'b1);
		acc(1, `IDN_PROBE1_RISE, 8'h00, 32'h00000005, 32'h00000000, ERR);
		acc(0, `IDN_PROBE1_RISE, 8'h00, 0, 32'hFFFFFFFF, 33'h000000011);
		acc(0, `IDN_PROBE1_FALL, 8'h00, 0, 32'hFFFFFFFF, 33'h000000022);
		acc(0, `IDN_PROBE2_RISE, 8'h00, 0, 32'hFFFFFFFF, 33'h0FFFFFF85);
		acc(0, `IDN_PROBE2_FALL, 8'h00, 0, 32'hFFFFFFFF, 33'h000000044);
		$display("probes done");
		test_done;
	end
endmodule
